// ---- common/ubi_consts.svh ----
// constants for the two-wire slave port of the usb bridge
// assumes a single 100 MHz core clock; included by bare name
`ifndef UBI_CONSTS_SVH
`define UBI_CONSTS_SVH

// core clock and the oscillator it stands in for
`define UBI_CLK_PERIOD_PS     10000
`define UBI_OSC_NOMINAL_KHZ   12000
`define UBI_OSC_TOL_PPM       1667

// supported two-wire bit rates in kbit/s
`define UBI_RATE_SM_KBPS      100
`define UBI_RATE_FM_KBPS      400
`define UBI_RATE_FMP_KBPS     1000
`define UBI_RATE_HS_KBPS      3400

// core samples in one high-speed bit, rounded down
`define UBI_HS_BIT_PS         (1000000000 / `UBI_RATE_HS_KBPS)
`define UBI_HS_SAMPLES        (`UBI_HS_BIT_PS / `UBI_CLK_PERIOD_PS)

// byte layout of the address phase and bit counts of a byte
`define UBI_ADDR_MSB          7
`define UBI_ADDR_LSB          1
`define UBI_DIR_BIT           0
`define UBI_BITS_PER_BYTE     4'h8
`define UBI_LAST_TX_FALL      4'h7

// reset values, fill byte and fifo depth
`define UBI_ADDR_RESET        7'h00
`define UBI_TX_FILL           8'hff
`define UBI_FIFO_DEPTH        4

`endif

// ---- common/ubi_pkg.sv ----
// types shared by the two-wire slave port
// no assumptions beyond a single clock domain
package ubi_pkg;
  typedef logic [7:0] ubi_byte_t;
  typedef logic [6:0] ubi_addr_t;

  typedef enum logic [2:0] {
    UBI_IDLE,
    UBI_ADDR,
    UBI_ADDR_ACK,
    UBI_RX,
    UBI_RX_ACK,
    UBI_TX,
    UBI_TX_ACK,
    UBI_IGNORE
  } ubi_state_e;
endpackage

// ---- rtl/ubi_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two; single clock
`timescale 1ns/1ps
`default_nettype none
module ubi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (push & ~pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop & ~push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/ubi_slave_port.sv ----
// two-wire slave port of a usb-to-serial bridge
// assumes an external master drives scl and pull-ups sit on both bus lines
`timescale 1ns/1ps
`default_nettype none
`include "ubi_consts.svh"
module ubi_slave_port #(
  parameter int FIFO_DEPTH = `UBI_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  // two-wire bus pins
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe_n,
  // configuration memory and auxiliary pin setup
  input  wire ubi_pkg::ubi_addr_t  config_mem_slave_addr,
  input  wire logic                aux_pin_power_enable_n_sel,
  // power and suspend
  input  wire logic                bus_power_detect_in,
  input  wire logic                usb_suspend_req,
  output logic                     suspend_active,
  output logic                     usb_dplus_line_pullup_en,
  output logic                     power_enable_n,
  // bytes from the usb host, read by the bus master
  input  wire logic                h2b_valid,
  output logic                     h2b_ready,
  input  wire ubi_pkg::ubi_byte_t  h2b_data,
  // bytes written by the bus master, toward the usb host
  output logic                     b2h_valid,
  input  wire logic                b2h_ready,
  output ubi_pkg::ubi_byte_t       b2h_data,
  // bus status
  output logic                     bus_busy,
  output logic                     addressed,
  output logic                     read_mode,
  output logic                     start_pulse,
  output logic                     stop_pulse,
  output logic                     rd_underrun_pulse,
  output logic                     wr_nack_pulse
);
  import ubi_pkg::*;

  // the core clock must sample a high-speed bit several times
  localparam int HS_SAMPLES = `UBI_HS_SAMPLES;

  function automatic logic addr_match(input ubi_byte_t b, input ubi_addr_t a);
    addr_match = (b[`UBI_ADDR_MSB:`UBI_ADDR_LSB] == a);
  endfunction

  function automatic ubi_byte_t tx_pick(input logic v, input ubi_byte_t d);
    tx_pick = v ? d : `UBI_TX_FILL;
  endfunction

  ubi_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  ubi_byte_t  rx_shift_reg;
  ubi_byte_t  tx_shift_reg;
  ubi_addr_t  own_addr_reg;
  logic       rw_reg;
  logic       sda_low_reg;
  logic       bus_busy_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       suspend_reg;
  logic       power_enable_n_n_reg;
  logic       pullup_reg;
  logic       start_p_reg;
  logic       stop_p_reg;
  logic       underrun_p_reg;
  logic       nack_p_reg;

  logic       scl_s;
  logic       sda_s;
  logic       vbus_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       byte_done;
  logic       load_tx;
  logic       rx_push;
  ubi_byte_t  tx_next;
  logic       txq_valid;
  ubi_byte_t  txq_data;
  logic       rxq_ready;

  // pins pass two flip-flops before decoding
  ubi_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h7)
  ) u_pin_sync (
    .clk   (ref_clk),
    .rst_n (reset_n),
    .d     ({scl_in, sda_in, bus_power_detect_in}),
    .q     ({scl_s, sda_s, vbus_s})
  );

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // edge and condition decode on synchronised lines
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign byte_done = scl_fall & (bit_cnt_reg == `UBI_BITS_PER_BYTE);

  // own address follows the configuration memory contents
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      own_addr_reg <= `UBI_ADDR_RESET;
    end else begin
      own_addr_reg <= config_mem_slave_addr;
    end
  end

  // suspend, d+ pull-up and power enable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      suspend_reg <= 1'b1;
      pullup_reg  <= 1'b0;
      power_enable_n_n_reg <= 1'b1;
    end else begin
      suspend_reg <= ~vbus_s | usb_suspend_req;
      pullup_reg  <= vbus_s;
      power_enable_n_n_reg <= ~(aux_pin_power_enable_n_sel & vbus_s & ~usb_suspend_req);
    end
  end

  // protocol state and bit counter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= UBI_IDLE;
      bit_cnt_reg <= 4'h0;
    end else if (suspend_reg | stop_det) begin
      state_reg   <= UBI_IDLE;
      bit_cnt_reg <= 4'h0;
    end else if (start_det) begin
      state_reg   <= UBI_ADDR;
      bit_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        UBI_ADDR, UBI_RX: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_done & (state_reg == UBI_RX)) begin
            state_reg <= UBI_RX_ACK;
          end else if (byte_done) begin
            state_reg <= addr_match(rx_shift_reg, own_addr_reg) ? UBI_ADDR_ACK : UBI_IGNORE;
          end
        end
        // rw_reg is always clear on the receive side
        UBI_ADDR_ACK, UBI_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= rw_reg ? UBI_TX : UBI_RX;
          end
        end
        UBI_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == `UBI_LAST_TX_FALL) begin
              bit_cnt_reg <= 4'h0;
              state_reg   <= UBI_TX_ACK;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        UBI_TX_ACK: begin
          if (scl_rise & sda_s) begin
            state_reg <= UBI_IGNORE;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= UBI_TX;
          end
        end
        UBI_IDLE, UBI_IGNORE: begin
          bit_cnt_reg <= 4'h0;
        end
        default: begin
          state_reg   <= UBI_IDLE;
          bit_cnt_reg <= 4'h0;
        end
      endcase
    end
  end

  // receive shifter, msb first
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_shift_reg <= 8'h00;
    end else if (scl_rise & ((state_reg == UBI_ADDR) | (state_reg == UBI_RX))) begin
      rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
    end
  end

  // direction bit of the last received address byte, matched or not; cleared on start
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rw_reg <= 1'b0;
    end else if (start_det) begin
      rw_reg <= 1'b0;
    end else if (byte_done & (state_reg == UBI_ADDR)) begin
      rw_reg <= rx_shift_reg[`UBI_DIR_BIT];
    end
  end

  // transmit byte load and shift
  assign load_tx = ~suspend_reg & ~start_det & ~stop_det & scl_fall &
                   (((state_reg == UBI_ADDR_ACK) & rw_reg) | (state_reg == UBI_TX_ACK));
  assign tx_next = tx_pick(txq_valid, txq_data);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift_reg <= 8'h00;
    end else if (load_tx) begin
      tx_shift_reg <= tx_next;
    end else if (scl_fall & (state_reg == UBI_TX)) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end
  end

  // sda pull-down; released on reset, start, stop and suspend
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_low_reg <= 1'b0;
    end else if (suspend_reg | start_det | stop_det) begin
      sda_low_reg <= 1'b0;
    end else begin
      case (state_reg)
        UBI_ADDR, UBI_RX: begin
          if (byte_done) begin
            sda_low_reg <= (state_reg == UBI_RX) ? rxq_ready : addr_match(rx_shift_reg, own_addr_reg);
          end
        end
        UBI_ADDR_ACK, UBI_RX_ACK: begin
          if (scl_fall) begin
            sda_low_reg <= rw_reg & ~tx_next[7];
          end
        end
        UBI_TX: begin
          if (scl_fall) begin
            sda_low_reg <= (bit_cnt_reg != `UBI_LAST_TX_FALL) & ~tx_shift_reg[6];
          end
        end
        UBI_TX_ACK: begin
          if (scl_fall) begin
            sda_low_reg <= ~tx_next[7];
          end
        end
        default: begin
          sda_low_reg <= 1'b0;
        end
      endcase
    end
  end

  // scl is input only; sda is open drain
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~sda_low_reg;

  // received bytes toward the host
  assign rx_push = byte_done & (state_reg == UBI_RX) & ~suspend_reg & ~start_det & ~stop_det;

  ubi_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_b2h_fifo (
    .clk       (ref_clk),
    .rst_n     (reset_n),
    .in_valid  (rx_push),
    .in_ready  (rxq_ready),
    .in_data   (rx_shift_reg),
    .out_valid (b2h_valid),
    .out_ready (b2h_ready),
    .out_data  (b2h_data)
  );

  // host bytes queued for master reads
  ubi_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_h2b_fifo (
    .clk       (ref_clk),
    .rst_n     (reset_n),
    .in_valid  (h2b_valid),
    .in_ready  (h2b_ready),
    .in_data   (h2b_data),
    .out_valid (txq_valid),
    .out_ready (load_tx),
    .out_data  (txq_data)
  );

  // bus busy between start and stop
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_busy_reg <= 1'b0;
    end else if (start_det) begin
      bus_busy_reg <= 1'b1;
    end else if (stop_det) begin
      bus_busy_reg <= 1'b0;
    end
  end

  // one-cycle status pulses
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_p_reg    <= 1'b0;
      stop_p_reg     <= 1'b0;
      underrun_p_reg <= 1'b0;
      nack_p_reg     <= 1'b0;
    end else begin
      start_p_reg    <= start_det;
      stop_p_reg     <= stop_det;
      underrun_p_reg <= load_tx & ~txq_valid;
      nack_p_reg     <= rx_push & ~rxq_ready;
    end
  end

  assign suspend_active           = suspend_reg;
  assign usb_dplus_line_pullup_en = pullup_reg & ~suspend_reg;
  assign power_enable_n           = power_enable_n_n_reg | suspend_reg;
  assign bus_busy                 = bus_busy_reg;
  assign addressed                = state_reg inside {UBI_ADDR_ACK, UBI_RX, UBI_RX_ACK, UBI_TX, UBI_TX_ACK};
  assign read_mode                = rw_reg;
  assign start_pulse              = start_p_reg;
  assign stop_pulse               = stop_p_reg;
  assign rd_underrun_pulse        = underrun_p_reg;
  assign wr_nack_pulse            = nack_p_reg;
endmodule
`default_nettype wire

// ---- rtl/ubi_sync.sv ----
// two flip-flop synchroniser for asynchronous pins
// assumes inputs may change at any time relative to clk
`timescale 1ns/1ps
`default_nettype none
module ubi_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      q        <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- tb/ubi_i2c_master.sv ----
// behavioural two-wire bus master, quarter bit of 10 clocks
// assumes the bench resolves sda with a pull-up
`timescale 1ns/1ps
`default_nettype none
module ubi_i2c_master (
  // clock
  input  wire logic ref_clk,
  // bus
  input  wire logic sda_in,
  output var logic  scl_in,
  output var logic  mst_sda_low
);
  initial begin
    scl_in = 1'b1;
    mst_sda_low = 1'b0;
  end
  task automatic q();
    repeat (10) @(posedge ref_clk);
  endtask
  // sda released first so this also serves as repeated start
  task automatic start();
    mst_sda_low <= 1'b0;
    q();
    scl_in <= 1'b1;
    q();
    mst_sda_low <= 1'b1;
    q();
    scl_in <= 1'b0;
    q();
  endtask
  task automatic stop();
    mst_sda_low <= 1'b1;
    q();
    scl_in <= 1'b1;
    q();
    mst_sda_low <= 1'b0;
    q();
  endtask
  // eight bits msb first, then the ninth acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    for (int i = 8; i >= 0; i--) begin
      mst_sda_low <= (i > 0) ? !tx[i-1] : !ack_in;
      q();
      scl_in <= 1'b1;
      q();
      if (i > 0) rx[i-1] = sda_in;
      else ack_out = sda_in;
      q();
      scl_in <= 1'b0;
      q();
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/ubi_slave_port_sva.sv ----
// pin-level assertions for the two-wire slave port
// bound to every ubi_slave_port; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module ubi_slave_port_sva (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               reset_n,
  // bus and power pins
  input wire logic               scl_in,
  input wire logic               sda_oe_n,
  input wire logic               bus_power_detect_in,
  input wire logic               usb_suspend_req,
  input wire logic               aux_pin_power_enable_n_sel,
  input wire logic               usb_dplus_line_pullup_en,
  input wire logic               power_enable_n,
  // streams and status
  input wire logic               b2h_valid,
  input wire logic               b2h_ready,
  input wire ubi_pkg::ubi_byte_t b2h_data,
  input wire logic               bus_busy,
  input wire logic               addressed,
  input wire logic               read_mode,
  input wire logic               start_pulse,
  input wire logic               stop_pulse,
  input wire logic               rd_underrun_pulse,
  input wire logic               wr_nack_pulse
);
  import ubi_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_reset_hiz: assert property (disable iff (1'b0) !reset_n |-> sda_oe_n)
    else $error("sda driven in reset");
  a_pullup_drop: assert property ($fell(bus_power_detect_in) |-> ##[1:6] !usb_dplus_line_pullup_en)
    else $error("pull-up kept without bus power");
  a_power_enable_n_suspend: assert property ($rose(usb_suspend_req) |-> ##[1:4] power_enable_n)
    else $error("power enable kept in suspend");
  a_power_enable_n_unsel: assert property (!aux_pin_power_enable_n_sel && !$past(aux_pin_power_enable_n_sel)
    && !$past(aux_pin_power_enable_n_sel, 2) |-> power_enable_n)
    else $error("power enable on unconfigured pin");
  a_start_busy: assert property (start_pulse |-> ##[0:1] bus_busy)
    else $error("start without busy");
  a_stop_free: assert property (stop_pulse |-> ##[0:1] !bus_busy)
    else $error("busy after stop");
  a_start_redecode: assert property (start_pulse |-> ##[0:2] !addressed)
    else $error("address kept over start");
  a_drive_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda changed with scl high");
  a_quiet_unaddr: assert property (!addressed && !$past(addressed) && !$past(addressed, 2) |-> sda_oe_n)
    else $error("sda driven while unaddressed");
  a_nack_full: assert property (wr_nack_pulse |-> sda_oe_n [*8])
    else $error("refused byte was acked");
  a_underrun_read: assert property (rd_underrun_pulse |-> read_mode)
    else $error("underrun outside read");
  a_b2h_hold: assert property (b2h_valid && !b2h_ready |=> b2h_valid && $stable(b2h_data))
    else $error("b2h byte dropped");
endmodule
bind ubi_slave_port ubi_slave_port_sva i_ubi_slave_port_sva (.*);
`default_nettype wire

// ---- tb/ubi_slave_port_tb.sv ----
// self-checking bench for the two-wire slave port
// assumes the master model and bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
module ubi_slave_port_tb;
  import ubi_pkg::*;
  localparam ubi_addr_t ADR = 7'h2a;
  logic      ref_clk = 1'b0;
  logic      reset_n = 1'b1;
  wire logic scl_in;
  wire logic mst_sda_low;
  wire logic sda_in;
  logic      sda_out, sda_oe_n, suspend_active, usb_dplus_line_pullup_en, power_enable_n;
  logic      h2b_ready, b2h_valid, bus_busy, addressed, read_mode;
  logic      start_pulse, stop_pulse, rd_underrun_pulse, wr_nack_pulse;
  ubi_byte_t b2h_data;
  ubi_byte_t h2b_data = 8'h00;
  ubi_addr_t config_mem_slave_addr = ADR;
  logic      aux_pin_power_enable_n_sel = 1'b1;
  logic      bus_power_detect_in = 1'b1;
  logic      usb_suspend_req = 1'b0;
  logic      h2b_valid = 1'b0;
  logic      b2h_ready = 1'b0;
  int        error_cnt = 0;
  int        n_tests = 0;
  // open-drain wire with pull-up
  assign sda_in = (mst_sda_low || !sda_oe_n) ? 1'b0 : 1'b1;
  always #5 ref_clk = ~ref_clk;
  ubi_slave_port i_ubi_slave_port (.*);
  ubi_i2c_master i_ubi_i2c_master (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] b, input logic nak);
    logic [7:0] r;
    logic       a;
    i_ubi_i2c_master.xfer(b, 1'b1, r, a);
    chk(a, nak);
  endtask
  task automatic rd(input logic [7:0] exp, input logic mnak);
    logic [7:0] r;
    logic       a;
    i_ubi_i2c_master.xfer(8'hff, mnak, r, a);
    chk(r, exp);
  endtask
  task automatic push(input logic [7:0] d);
    int n = 0;
    h2b_valid <= 1'b1;
    h2b_data <= d;
    @(posedge ref_clk);
    while (h2b_ready !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    h2b_valid <= 1'b0;
    @(posedge ref_clk);
    if (n == 50) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic pop(input logic [7:0] exp);
    int n = 0;
    while (b2h_valid !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 50) begin
      error_cnt++;
      final_report();
    end
    chk(b2h_data, exp);
    b2h_ready <= 1'b1;
    @(posedge ref_clk);
    b2h_ready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic t_power();
    repeat (8) @(posedge ref_clk);
    chk(suspend_active, 1'b0);
    chk(usb_dplus_line_pullup_en, 1'b1);
    chk(power_enable_n, 1'b0);
    usb_suspend_req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(power_enable_n, 1'b1);
    chk(suspend_active, 1'b1);
    usb_suspend_req <= 1'b0;
    bus_power_detect_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(usb_dplus_line_pullup_en, 1'b0);
    chk(power_enable_n, 1'b1);
    bus_power_detect_in <= 1'b1;
    aux_pin_power_enable_n_sel <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(power_enable_n, 1'b1);
    aux_pin_power_enable_n_sel <= 1'b1;
    repeat (8) @(posedge ref_clk);
    $display("test power done");
  endtask
  // five bytes into a four-deep queue while the host side stalls
  task automatic t_write();
    i_ubi_i2c_master.start();
    chk(bus_busy, 1'b1);
    wr({ADR, 1'b0}, 1'b0);
    chk(addressed, 1'b1);
    chk(read_mode, 1'b0);
    for (int i = 0; i < 5; i++) wr(8'h81 + 8'(i) * 8'h11, i == 4);
    i_ubi_i2c_master.stop();
    chk(bus_busy, 1'b0);
    for (int i = 0; i < 4; i++) pop(8'h81 + 8'(i) * 8'h11);
    chk(b2h_valid, 1'b0);
    $display("test write done");
  endtask
  task automatic t_read();
    for (int i = 0; i < 4; i++) push(8'h3c + 8'(i));
    chk(h2b_ready, 1'b0);
    i_ubi_i2c_master.start();
    wr({ADR, 1'b0}, 1'b0);
    i_ubi_i2c_master.start();
    wr({ADR, 1'b1}, 1'b0);
    chk(read_mode, 1'b1);
    for (int i = 0; i < 4; i++) rd(8'h3c + 8'(i), i == 3);
    i_ubi_i2c_master.stop();
    i_ubi_i2c_master.start();
    wr({ADR, 1'b1}, 1'b0);
    rd(8'hff, 1'b1);
    i_ubi_i2c_master.stop();
    $display("test read done");
  endtask
  task automatic t_addr();
    config_mem_slave_addr <= 7'h55;
    i_ubi_i2c_master.start();
    wr({ADR, 1'b0}, 1'b1);
    wr(8'h00, 1'b1);
    i_ubi_i2c_master.start();
    wr({7'h55, 1'b0}, 1'b0);
    wr(8'h77, 1'b0);
    i_ubi_i2c_master.stop();
    pop(8'h77);
    $display("test address done");
  endtask
  initial begin
    // reset falls at time zero so the asynchronous branches see an edge
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk(sda_oe_n, 1'b1);
    chk(usb_dplus_line_pullup_en, 1'b0);
    reset_n <= 1'b1;
    t_power();
    t_write();
    t_read();
    t_addr();
    final_report();
  end
endmodule
`default_nettype wire
